// File: rtl/apc_adc_ctl.sv
// Contract
// R01 - Low-latency settle pin picks settling style
// R02 - Path pin picks wide-bandwidth or low-latency filter
// R03 - Start begins, resets and synchronises conversions
// R04 - Start high one clock, sampled on clock
// R05 - Chip select active low gates serial port
// R06 - Out-of-range flag output driven
// R07 - Complement shift clock inverse, else high impedance
// R08 - Shift clock driven internally, else host input
// R09 - Internal shift clock period; ready pulse width
// R10 - New data bit after shift clock rise
// R11 - Host ends shifting three clocks before ready
// R12 - Deselected serial output is high impedance
// R13 - Source select pin chooses shift clock origin
// R14 - Interface pin selects differential or single-ended
// R15 - Rate code selects output data rate
// R16 - Results are 24-bit two's complement
// R17 - Result shifted out MSB first
// R18 - Exactly one internal pulse per bit
`timescale 1ns/1ps
module apc_adc_ctl (
  // Clocks and reset
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire logic                      sclk_in,
  // Static configuration pins
  input  wire logic                      low_latency_settle_sel,
  input  wire logic                      filter_path_sel,
  input  wire logic [1:0]                output_rate_sel,
  input  wire logic                      sclk_src_sel,
  input  wire logic                      lvds_n_sel,
  input  wire logic                      power_down_n,
  // Conversion control pins
  input  wire logic                      start,
  input  wire logic                      cs_n,
  // Filter result, same clock
  input  wire logic [apc_pkg::RES_W-1:0] filter_data,
  input  wire logic                      filter_ovr,
  // Filter and status outputs
  output logic                           filter_reset,
  output logic                           result_ready_pulse,
  output logic                           result_ready_n,
  output logic                           out_of_range_flag,
  output logic                           lvds_mode,
  // Shift clock pins
  output logic                           sclk_out,
  output logic                           sclk_oe,
  output logic                           sclk_n_out,
  output logic                           sclk_n_oe,
  // Serial data pins
  output logic                           dout,
  output logic                           dout_oe,
  output logic                           dout_n,
  output logic                           dout_n_oe
);

  apc_xfer_if xf ();

  logic [apc_pkg::PIN_W-1:0] pin_raw;
  logic [apc_pkg::PIN_W-1:0] pin_s1_r;
  logic [apc_pkg::PIN_W-1:0] pin_s2_r;
  logic                      start_d_r;
  logic                      start_rise;
  logic                      ll_s;
  logic                      path_s;
  logic [1:0]                rate_s;
  logic                      int_mode;
  logic                      cs_s;
  logic                      power_down_n_s;
  logic                      lvds_n_s;

  apc_pkg::apc_conv_state_t  state_r;
  logic [apc_pkg::CNT_W-1:0] cnt_r;
  logic [apc_pkg::CNT_W-1:0] period;
  logic [apc_pkg::CNT_W-1:0] target;
  logic [2:0]                settle_r;
  logic                      first_r;
  logic                      conv_end;
  logic                      emit;

  logic [apc_pkg::RES_W-1:0] word_r;
  logic                      result_ready_pulse_r;
  logic                      result_ready_pulse_n_r;
  logic                      ovr_r;
  logic                      frame_clr_r;
  logic                      frst_r;

  logic                      shifting_r;
  logic [apc_pkg::IDX_W-1:0] idx_r;
  logic                      sclk_int_r;
  logic                      sclk_n_r;
  logic                      dout_int_r;
  logic                      sclk_oe_r;
  logic                      sclk_n_oe_r;
  logic                      dout_oe_r;
  logic                      dout_n_oe_r;
  logic                      lvds_r;

  // Cycles of the master clock per output word for a path and rate code; scale first so only one divide truncates
  function automatic logic [apc_pkg::CNT_W-1:0] rate_cycles(input logic ll_path, input logic [1:0] code);
    int cyc;
    cyc = ll_path ? (apc_pkg::CLK_HZ * apc_pkg::RATE_SCALE) / apc_pkg::LL_RATE_DSPS[code]
                  : (apc_pkg::CLK_HZ * apc_pkg::RATE_SCALE) / apc_pkg::WB_RATE_DSPS[code];
    return apc_pkg::CNT_W'(cyc);
  endfunction

  // Pin vector gathered for synchronisation
  assign pin_raw = {cs_n, start, power_down_n, lvds_n_sel, sclk_src_sel,
                    output_rate_sel, filter_path_sel, low_latency_settle_sel};

  // Two-flop synchroniser per pin; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < apc_pkg::PIN_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pin_s1_r[gi] <= apc_pkg::PIN_RST[gi];
          pin_s2_r[gi] <= apc_pkg::PIN_RST[gi];
        end else begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi]; // [R04]
        end
      end
    end
  endgenerate

  // Decoded pin levels
  assign ll_s     = pin_s2_r[apc_pkg::PIN_LL];
  assign path_s   = pin_s2_r[apc_pkg::PIN_PATH];
  assign rate_s   = pin_s2_r[apc_pkg::PIN_RATE_HI:apc_pkg::PIN_RATE_LO];
  assign int_mode = ~pin_s2_r[apc_pkg::PIN_SCLK_SEL]; // [R13]
  assign lvds_n_s = pin_s2_r[apc_pkg::PIN_LVDS_N];
  assign power_down_n_s   = pin_s2_r[apc_pkg::PIN_POWER_DOWN_N_N];
  assign cs_s     = pin_s2_r[apc_pkg::PIN_CS_N];

  // Start edge detect on the synchronised level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      start_d_r <= 1'b0;
    end else begin
      start_d_r <= pin_s2_r[apc_pkg::PIN_START];
    end
  end

  assign start_rise = pin_s2_r[apc_pkg::PIN_START] & ~start_d_r; // [R03] [R04]

  // Word period; on the low-latency path fast response gives its first word after half a period
  assign period   = rate_cycles(path_s, rate_s); // [R02] [R15]
  assign target   = (first_r && path_s && ll_s) ? (period >> 1) : period; // [R01]
  assign conv_end = (state_r == apc_pkg::CV_RUN) && (cnt_r >= target - 12'h001);
  assign emit     = conv_end && (settle_r == 3'h0) && !start_rise && power_down_n_s;

  // Conversion sequencer; a start edge restarts from zero unless power down is active
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r  <= apc_pkg::CV_IDLE;
      cnt_r    <= '0;
      settle_r <= 3'h0;
      first_r  <= 1'b0;
    end else if (!power_down_n_s) begin
      state_r  <= apc_pkg::CV_IDLE;
      cnt_r    <= '0;
    end else if (start_rise) begin
      state_r  <= apc_pkg::CV_RUN; // [R03]
      cnt_r    <= '0;
      settle_r <= path_s ? 3'h0 : apc_pkg::WB_SETTLE_CONV; // [R01] [R02]
      first_r  <= 1'b1;
    end else begin
      case (state_r)
        apc_pkg::CV_RUN: begin
          if (conv_end) begin
            cnt_r   <= '0;
            first_r <= 1'b0;
            if (settle_r != 3'h0) begin
              settle_r <= settle_r - 3'h1;
            end
          end else begin
            cnt_r <= cnt_r + 12'h001;
          end
        end
        default: begin
          cnt_r <= '0;
        end
      endcase
    end
  end

  // Result capture; overrange saturates to the full-scale code of its sign
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      word_r      <= '0;
      result_ready_pulse_r      <= 1'b0;
      result_ready_pulse_n_r    <= 1'b1;
      ovr_r       <= 1'b0;
      frame_clr_r <= 1'b1;
      frst_r      <= 1'b1;
    end else begin
      result_ready_pulse_r      <= emit; // [R09]
      result_ready_pulse_n_r    <= ~emit;
      frame_clr_r <= emit;
      frst_r      <= start_rise | ~power_down_n_s; // [R03]
      if (emit) begin
        word_r <= filter_ovr ? (filter_data[apc_pkg::RES_W-1] ? apc_pkg::FULL_NEG : apc_pkg::FULL_POS)
                             : filter_data; // [R16]
        ovr_r  <= filter_ovr; // [R06]
      end
    end
  end

  // Internal shift engine: two master cycles per bit, idle low between words
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shifting_r <= 1'b0;
      idx_r      <= '0;
      sclk_int_r <= 1'b0;
      sclk_n_r   <= 1'b1;
      dout_int_r <= 1'b0;
    end else if (cs_s || !int_mode) begin
      shifting_r <= 1'b0; // [R05]
      sclk_int_r <= 1'b0;
      sclk_n_r   <= 1'b1;
    end else if (result_ready_pulse_r) begin
      shifting_r <= 1'b1;
      idx_r      <= apc_pkg::IDX_W'(apc_pkg::RES_W - 1); // [R17]
      sclk_int_r <= 1'b0;
      sclk_n_r   <= 1'b1;
    end else if (shifting_r) begin
      if (!sclk_int_r) begin
        sclk_int_r <= 1'b1; // [R18]
        sclk_n_r   <= 1'b0; // [R07]
        dout_int_r <= word_r[idx_r]; // [R10]
      end else begin
        sclk_int_r <= 1'b0;
        sclk_n_r   <= 1'b1;
        if (idx_r == 5'h00) begin
          shifting_r <= 1'b0; // [R18]
        end else begin
          idx_r <= idx_r - 5'h01;
        end
      end
    end
  end

  // Pad enables and signalling mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclk_oe_r   <= 1'b0;
      sclk_n_oe_r <= 1'b0;
      dout_oe_r   <= 1'b0;
      dout_n_oe_r <= 1'b0;
      lvds_r      <= 1'b0;
    end else begin
      sclk_oe_r   <= int_mode; // [R08]
      sclk_n_oe_r <= int_mode; // [R07]
      dout_oe_r   <= ~cs_s; // [R05] [R12]
      dout_n_oe_r <= ~cs_s & ~lvds_n_s; // [R14]
      lvds_r      <= ~lvds_n_s; // [R14]
    end
  end

  // Link side shifter on the host clock
  assign xf.word      = word_r;
  assign xf.frame_clr = frame_clr_r;

  apc_ext_shift u_ext (
    .sclk_in (sclk_in),
    .xf      (xf.shf)
  );

  // Outputs; data pin selects between the two shift engines by mode
  assign filter_reset       = frst_r;
  assign result_ready_pulse = result_ready_pulse_r;
  assign result_ready_n     = result_ready_pulse_n_r;
  assign out_of_range_flag  = ovr_r;
  assign lvds_mode          = lvds_r;
  assign sclk_out           = sclk_int_r;
  assign sclk_oe            = sclk_oe_r;
  assign sclk_n_out         = sclk_n_r;
  assign sclk_n_oe          = sclk_n_oe_r;
  assign dout               = int_mode ? dout_int_r : xf.dout_ext;
  assign dout_oe            = dout_oe_r;
  assign dout_n             = ~dout;
  assign dout_n_oe          = dout_n_oe_r;

  // Checks on the master clock
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  localparam int IDX_W_A = 6;
  logic [IDX_W_A-1:0] pulse_cnt_r;

  // Counts cycles with the internal shift clock high; a stuck-high clock counts too many
  always_ff @(posedge ref_clk) begin
    if (reset || result_ready_pulse_r) begin
      pulse_cnt_r <= '0;
    end else if (sclk_int_r && pulse_cnt_r != 6'h3F) begin
      pulse_cnt_r <= pulse_cnt_r + 6'h01;
    end
  end

  // Ready pulse, restart and pad checks
  result_ready_pulse_width_a: assert property (result_ready_pulse_r |=> !result_ready_pulse_r ##0 result_ready_n) // [R09]
    else $error("result ready pulse not one cycle");
  start_restart_a: assert property (start_rise && power_down_n_s |=> cnt_r == 12'h000 && filter_reset
                                    && state_r == apc_pkg::CV_RUN) // [R03]
    else $error("start edge did not restart conversion");
  sclk_oe_sel_a: assert property ($stable(int_mode) [*2] ##0 !$past(reset)
                                  |-> sclk_oe == int_mode && sclk_n_oe == int_mode) // [R07] [R08]
    else $error("shift clock enables disagree with source select");
  sclk_compl_a: assert property (sclk_n_oe |-> sclk_n_out == ~sclk_out) // [R07]
    else $error("complement shift clock not inverse");
  cs_tristate_a: assert property (cs_s [*2] |-> !dout_oe && !dout_n_oe) // [R05] [R12]
    else $error("data driven while deselected");
  ovr_clamp_a: assert property (result_ready_pulse_r && out_of_range_flag |-> word_r == apc_pkg::FULL_POS
                                || word_r == apc_pkg::FULL_NEG) // [R06] [R16]
    else $error("overrange word not full scale");
  msb_first_a: assert property (result_ready_pulse_r && int_mode && !cs_s ##1 !cs_s && int_mode |=> sclk_int_r
                                && dout_int_r == word_r[apc_pkg::RES_W-1]) // [R17] [R10]
    else $error("first bit is not the MSB");
  pulse_count_a: assert property ($fell(shifting_r) && !cs_s && int_mode |-> pulse_cnt_r == 6'h18) // [R18]
    else $error("internal shift clock pulse count wrong");
  sclk_idle_a: assert property (!shifting_r |=> !sclk_int_r) // [R18]
    else $error("shift clock active while idle");
  word_period_a: assert property ($stable(pin_s2_r) [*2] ##0 result_ready_pulse_r |=> !result_ready_pulse_r [*8]) // [R15]
    else $error("result ready too soon after previous");

  // Start arms settling for the selected path; power down and mode pins
  settle_wb_a: assert property (start_rise && power_down_n_s && !path_s |=> settle_r == apc_pkg::WB_SETTLE_CONV) // [R02]
    else $error("wide-bandwidth start did not arm the discard count");
  settle_ll_a: assert property (start_rise && power_down_n_s && path_s |=> settle_r == 3'h0 && first_r) // [R01]
    else $error("low-latency start did not arm single-word settling");
  power_down_n_idle_a: assert property (!power_down_n_s |=> state_r == apc_pkg::CV_IDLE && filter_reset) // [R03]
    else $error("power down did not idle the sequencer");
  word_hold_a: assert property (!emit |=> $stable(word_r)) // [R17]
    else $error("result word changed without a ready pulse");
  lvds_mode_a: assert property ($stable(lvds_n_s) ##0 !$past(reset) |-> lvds_mode == !lvds_n_s) // [R14]
    else $error("signalling mode does not follow the select pin");
  ext_oe_off_a: assert property (!int_mode |=> !sclk_oe && !sclk_n_oe) // [R07] [R08]
    else $error("shift clock pins driven in external mode");

  word_int_c:  cover property (result_ready_pulse_r && int_mode && !cs_s ##[1:60] $fell(shifting_r));
  word_ext_c:  cover property (result_ready_pulse_r && !int_mode && !cs_s);
  ovr_c:       cover property (result_ready_pulse_r && out_of_range_flag);
  restart_c:   cover property (start_rise && state_r == apc_pkg::CV_RUN);
  fast_c:      cover property (start_rise && path_s && ll_s && power_down_n_s);

endmodule // apc_adc_ctl

// File: rtl/apc_ext_shift.sv
`timescale 1ns/1ps
module apc_ext_shift (
  // Host shift clock
  input wire logic sclk_in,
  // Word and frame clear from the master domain
  apc_xfer_if.shf  xf
);

  logic [apc_pkg::IDX_W-1:0] count_r;
  logic                      dout_r;

  // Frame clear is a master-domain flop; the host keeps its clock quiet
  // around result ready, so the word is stable while it is shifted out
  always_ff @(posedge sclk_in or posedge xf.frame_clr) begin
    if (xf.frame_clr) begin
      count_r <= '0;
      dout_r  <= 1'b0;
    end else if (count_r < apc_pkg::IDX_W'(apc_pkg::RES_W)) begin // [R11]
      dout_r  <= xf.word[apc_pkg::IDX_W'(apc_pkg::RES_W - 1) - count_r]; // [R10] [R17]
      count_r <= count_r + 5'h01;
    end
  end

  assign xf.dout_ext = dout_r;

endmodule // apc_ext_shift

// File: rtl/apc_pkg.sv
package apc_pkg;

  // Result word and counter widths
  localparam int RES_W = 24;
  localparam int CNT_W = 12;
  localparam int IDX_W = 5;

  // Master clock
  localparam int CLK_HZ        = 125_000_000;
  localparam int CLK_PERIOD_NS = 8;

  // Output rates in tenths of a sample per second, indexed by the rate code
  localparam int LL_RATE_DSPS [4] = '{360000, 680000, 1200000, 1800000};
  localparam int WB_RATE_DSPS [4] = '{781000, 1563000, 3125000, 6250000};
  localparam int RATE_SCALE       = 10;

  // Timing figures in master clock periods
  localparam int START_MIN_TCLK   = 1;
  localparam int START_SETUP_X10  = 5;
  localparam int RESULT_READY_PULSE_MIN_TCLK    = 1;
  localparam int SCLK_PERIOD_TCLK = 1;
  localparam int EXT_GAP_TCLK     = 3;

  // Conversions discarded after a start on the wide-bandwidth path
  localparam logic [2:0] WB_SETTLE_CONV = 3'h4;

  // Full-scale output codes
  localparam logic [RES_W-1:0] FULL_POS = 24'h7FFFFF;
  localparam logic [RES_W-1:0] FULL_NEG = 24'h800000;

  // Bit positions of the synchronised pin vector
  localparam int PIN_LL       = 0;
  localparam int PIN_PATH     = 1;
  localparam int PIN_RATE_LO  = 2;
  localparam int PIN_RATE_HI  = 3;
  localparam int PIN_SCLK_SEL = 4;
  localparam int PIN_LVDS_N   = 5;
  localparam int PIN_POWER_DOWN_N_N   = 6;
  localparam int PIN_START    = 7;
  localparam int PIN_CS_N     = 8;
  localparam int PIN_W        = 9;
  localparam logic [PIN_W-1:0] PIN_RST = 9'h100;

  // Conversion sequencer states
  typedef enum logic {CV_IDLE, CV_RUN} apc_conv_state_t;

endpackage

// File: rtl/apc_xfer_if.sv
`timescale 1ns/1ps
interface apc_xfer_if;
  logic [apc_pkg::RES_W-1:0] word;
  logic                      frame_clr;
  logic                      dout_ext;

  modport ctl (output word, output frame_clr, input dout_ext);
  modport shf (input word, input frame_clr, output dout_ext);
endinterface

// File: tb/apc_host_model.sv
`timescale 1ns/1ps
module apc_host_model (
  // Frame request and serial data
  input  wire logic        go,
  input  wire logic        dout,
  // Host shift clock
  output logic             sclk_in,
  // Captured word
  output logic [23:0]      word,
  output logic             done
);
  initial begin
    sclk_in = 1'b0;
    word    = 24'h000000;
    done    = 1'b0;
  end

  // One burst of 24 rises per request; clock parked low between frames
  // Bench raises go only well clear of the next ready pulse
  always @(posedge go) begin
    done = 1'b0;
    #3;
    for (int i = 0; i < 24; i++) begin
      #6 sclk_in = 1'b1;
      #6 sclk_in = 1'b0;
      word = {word[22:0], dout}; // Sampled on the falling edge
    end
    done = 1'b1;
  end
endmodule // apc_host_model

// File: tb/tb_apc_adc_ctl.sv
`timescale 1ns/1ps
module tb_apc_adc_ctl;
  // Clock, reset and driven pins
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  logic        ll_sel  = 1'b0;
  logic        path    = 1'b1;
  logic [1:0]  rate    = 2'h3;
  logic        src     = 1'b0;
  logic        lvds_n  = 1'b1;
  logic        pwr_n   = 1'b1;
  logic        start   = 1'b0;
  logic        cs_n    = 1'b0;
  logic [23:0] fdata   = 24'h000000;
  logic        fovr    = 1'b0;
  logic        go      = 1'b0;
  // Observed outputs
  logic        sclk_in, frst, rdy, rdy_n, otr, lvds_m, sclk, sclk_oe, sclk_n, sclk_n_oe;
  logic        dout, dout_oe, dout_n, dout_n_oe, hdone;
  logic [23:0] hword, w;
  // Reference model state
  int          err_count = 0;
  int          cmp_count = 0;
  int          n, lat, t, r;
  logic [23:0] exp_q [$];

  always #4 ref_clk = ~ref_clk;

  apc_adc_ctl dut (.ref_clk(ref_clk), .reset(reset), .sclk_in(sclk_in), .low_latency_settle_sel(ll_sel),
    .filter_path_sel(path), .output_rate_sel(rate), .sclk_src_sel(src), .lvds_n_sel(lvds_n),
    .power_down_n(pwr_n), .start(start), .cs_n(cs_n), .filter_data(fdata), .filter_ovr(fovr),
    .filter_reset(frst), .result_ready_pulse(rdy), .result_ready_n(rdy_n), .out_of_range_flag(otr),
    .lvds_mode(lvds_m), .sclk_out(sclk), .sclk_oe(sclk_oe), .sclk_n_out(sclk_n), .sclk_n_oe(sclk_n_oe),
    .dout(dout), .dout_oe(dout_oe), .dout_n(dout_n), .dout_n_oe(dout_n_oe));

  apc_host_model host (.go(go), .dout(dout), .sclk_in(sclk_in), .word(hword), .done(hdone));

  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Cycles until the next ready pulse, bounded
  task automatic wait_ready(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1 c++;
    end while (rdy !== 1'b1 && c < 25000);
  endtask

  // Start held four cycles, longer than the sync stages need
  task automatic do_start();
    logic seen;
    seen = 1'b0;
    @(posedge ref_clk) start <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      if (i == 3) start <= 1'b0;
      #1 seen |= frst;
    end
    check(seen, 1'b1);
  endtask

  // Data lands on the word after the next ready
  task automatic send_word(input logic [23:0] d, input logic o);
    wait_ready(n);
    @(posedge ref_clk);
    fdata <= d;
    fovr  <= o;
    exp_q.push_back(o ? (d[23] ? apc_pkg::FULL_NEG : apc_pkg::FULL_POS) : d);
    wait_ready(n);
    check(otr, o);
  endtask

  // Bits taken at each internal clock rise
  task automatic capture_int(output logic [23:0] v, output int c);
    logic prev, bad;
    prev = 1'b0;
    bad  = 1'b0;
    c    = 0;
    v    = 24'h000000;
    repeat (60) begin
      @(posedge ref_clk);
      #1 bad |= (sclk_n !== ~sclk) || (dout_n !== ~dout);
      if (sclk && !prev) begin
        c++;
        v = {v[22:0], dout};
      end
      prev = sclk;
    end
    check(bad, 1'b0);
  endtask

  // Hang guard, well past the expected run
  initial begin
    #720000;
    err_count++;
    $display("Error at %0t: watchdog got %h exp %h", $time, 0, 1);
    end_sim();
  end

  initial begin
    void'($urandom(47372));
    repeat (2) @(posedge ref_clk);
    #1 check({frst, rdy, rdy_n, sclk_n, dout_oe}, 5'h16);
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check({sclk_oe, sclk_n_oe, dout_oe}, 3'h7);
    for (int v = 1; v >= 0; v--) begin
      @(posedge ref_clk) lvds_n <= v[0];
      cs_n <= v[0];
      repeat (4) @(posedge ref_clk);
      #1 check({lvds_m, dout_oe, dout_n_oe}, v ? 3'h0 : 3'h7);
    end
    @(posedge ref_clk) pwr_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 check(frst, 1'b1);
    @(posedge ref_clk) pwr_n <= 1'b1;
    $display("Test pins done");
    // Every path and rate code: start latency and word period
    for (int p = 1; p >= 0; p--) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge ref_clk) path <= p[0];
        rate <= c[1:0];
        t = apc_pkg::CLK_HZ * apc_pkg::RATE_SCALE / (p ? apc_pkg::LL_RATE_DSPS[c] : apc_pkg::WB_RATE_DSPS[c]);
        repeat (4) @(posedge ref_clk);
        do_start();
        wait_ready(n);
        if (p == 1 && c == 0) lat = n - t;
        else check(n, (p ? 1 : apc_pkg::WB_SETTLE_CONV + 1) * t + lat);
        wait_ready(n);
        check(n, t);
        @(posedge ref_clk);
        #1 check({rdy, rdy_n}, 2'h1);
      end
    end
    $display("Test rates done");
    @(posedge ref_clk) path <= 1'b1;
    rate   <= 2'h3;
    ll_sel <= 1'b1;
    t = apc_pkg::CLK_HZ * apc_pkg::RATE_SCALE / apc_pkg::LL_RATE_DSPS[3];
    repeat (4) @(posedge ref_clk);
    do_start();
    wait_ready(n);
    check(n, t / 2 + lat);
    $display("Test settle done");
    // Internal shift: plain, both overrange signs, negative full scale
    for (int k = 0; k < 4; k++) begin
      w = 24'($urandom);
      if (k == 1) w[23] = 1'b0;
      if (k == 2) w[23] = 1'b1;
      if (k == 3) w = apc_pkg::FULL_NEG;
      send_word(w, k == 1 || k == 2);
      capture_int(w, r);
      check(w, exp_q.pop_front());
      check(r, 24);
    end
    $display("Test internal shift done");
    @(posedge ref_clk) src <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 check({sclk_oe, sclk_n_oe}, 2'h0);
    send_word(24'($urandom), 1'b0);
    repeat (4) @(posedge ref_clk);
    go <= 1'b1;
    for (int i = 0; i < 100 && hdone !== 1'b1; i++) @(posedge ref_clk);
    go <= 1'b0;
    check(hdone, 1'b1);
    check(hword, exp_q.pop_front());
    $display("Test external shift done");
    end_sim();
  end
endmodule // tb_apc_adc_ctl
